/* File: core/bccu_pkg.sv */
package bccu_pkg;

	// Register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] OFF_CMD   = 8'h00;
	localparam logic [7:0] OFF_CIA   = 8'h04;
	localparam logic [7:0] OFF_DISP  = 8'h08;
	localparam logic [7:0] OFF_CTR   = 8'h0C;
	localparam logic [7:0] OFF_RET   = 8'h10;
	localparam logic [7:0] OFF_COND  = 8'h14;
	localparam logic [7:0] OFF_LEFT  = 8'h18;
	localparam logic [7:0] OFF_RIGHT = 8'h1C;
	localparam logic [7:0] OFF_SOVF  = 8'h20;
	localparam logic [7:0] OFF_NIA   = 8'h24;
	localparam logic [7:0] OFF_STAT  = 8'h28;

	// Command word layout
	localparam int CMD_OP_LSB  = 0;
	localparam int CMD_BO_LSB  = 4;
	localparam int CMD_BI_LSB  = 9;
	localparam int CMD_AA_BIT  = 14;
	localparam int CMD_LK_BIT  = 15;
	localparam int CMD_CRF_LSB = 16;
	localparam int CMD_WIDE_BIT = 19;

	// Status word layout
	localparam int STAT_TAKEN_BIT   = 0;
	localparam int STAT_HINT_BIT    = 1;
	localparam int STAT_INVALID_BIT = 2;

	// Operation codes
	localparam logic [2:0] OP_BC    = 3'h0;
	localparam logic [2:0] OP_BCCTR = 3'h1;
	localparam logic [2:0] OP_BCLR  = 3'h2;
	localparam logic [2:0] OP_CMP   = 3'h3;
	localparam logic [2:0] OP_CMPI  = 3'h4;
	localparam logic [2:0] OP_CMPL  = 3'h5;

	localparam int DISP_W = 14;
	localparam int IMM_W  = 16;
	localparam logic [31:0] INSTR_STEP = 32'h0000_0004;
	localparam logic [31:0] RST_WORD   = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// Compare result as a one-hot triple: less, greater, equal
	typedef logic [2:0] bccu_cmp_t;

endpackage : bccu_pkg

/* File: core/bccu_core.sv */
`timescale 1ns/1ps
module bccu_core (
	// Clock, reset, enable
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Fetch side
	output logic [31:0]      next_instr_addr_q,
	output logic             branch_taken_q,
	output logic             predict_hint_q,
	output logic             invalid_form_q,
	output logic             result_valid_q
);

	function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] val,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) r[i*8 +: 8] = val[i*8 +: 8];
		end
		return r;
	endfunction : apply_strb

	// Picks the less/greater/equal bits of one 4-bit field, field 0 in the top nibble
	function automatic bccu_pkg::bccu_cmp_t field_bits(input logic [31:0] cr, input logic [2:0] f);
		logic [4:0] base;
		base = 5'd28 - {f, 2'b00};
		return cr[base + 5'd1 +: 3];
	endfunction : field_bits

	// Register state
	logic [31:0] cmd_q, cia_q, disp_q, ctr_q, ret_q, cond_q, left_q, right_q;
	logic        sovf_q, exec_q;

	// Bus channel state
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q, rd_word;
	logic [3:0]  w_strb_q;
	logic        aw_hold_q, w_hold_q, wr_go, wr_hit, rd_hit;

	assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;

	always_comb begin
		wr_hit = 1'b1;
		case (aw_addr_q)
			bccu_pkg::OFF_CMD, bccu_pkg::OFF_CIA, bccu_pkg::OFF_DISP, bccu_pkg::OFF_CTR,
			bccu_pkg::OFF_RET, bccu_pkg::OFF_COND, bccu_pkg::OFF_LEFT, bccu_pkg::OFF_RIGHT,
			bccu_pkg::OFF_SOVF: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// Decoded command fields
	logic [2:0]  op, target_cond_field;
	logic [0:4]  branch_options;
	logic [4:0]  cond_select;
	logic        absolute_target_flag, link_flag, wide_mode, is_branch, is_cmp;

	assign op                   = cmd_q[bccu_pkg::CMD_OP_LSB +: 3];
	assign branch_options       = cmd_q[bccu_pkg::CMD_BO_LSB +: 5];
	assign cond_select          = cmd_q[bccu_pkg::CMD_BI_LSB +: 5];
	assign absolute_target_flag = cmd_q[bccu_pkg::CMD_AA_BIT];
	assign link_flag            = cmd_q[bccu_pkg::CMD_LK_BIT];
	assign target_cond_field    = cmd_q[bccu_pkg::CMD_CRF_LSB +: 3];
	assign wide_mode            = cmd_q[bccu_pkg::CMD_WIDE_BIT];
	assign is_branch = (op == bccu_pkg::OP_BC) || (op == bccu_pkg::OP_BCCTR) || (op == bccu_pkg::OP_BCLR);
	assign is_cmp    = (op == bccu_pkg::OP_CMP) || (op == bccu_pkg::OP_CMPI) || (op == bccu_pkg::OP_CMPL);

	// Branch resolution
	logic        dec_en, ctr_ok, cond_bit, cond_ok, take, br_invalid;
	logic [31:0] ctr_dec, disp_ext, target, seq_addr;

	// Counter-register form never touches the counter
	assign dec_en   = !branch_options[2] && (op != bccu_pkg::OP_BCCTR);
	assign ctr_dec  = ctr_q - 32'h0000_0001;
	// Only bits 0..3 feed the decisions; bit 4 is the hint
	assign ctr_ok   = branch_options[2] || ((ctr_dec != bccu_pkg::RST_WORD) ^ branch_options[3]);
	assign cond_bit = cond_q[5'd31 - cond_select];
	assign cond_ok  = branch_options[0] || (cond_bit == branch_options[1]);
	assign br_invalid = (op == bccu_pkg::OP_BCCTR) && !branch_options[2];
	assign take     = (op == bccu_pkg::OP_BCCTR) ? cond_ok : (ctr_ok && cond_ok);
	assign disp_ext = {{(32 - bccu_pkg::DISP_W - 2){disp_q[bccu_pkg::DISP_W-1]}},
		disp_q[bccu_pkg::DISP_W-1:0], 2'b00};
	assign seq_addr = cia_q + bccu_pkg::INSTR_STEP;

	always_comb begin
		case (op)
			bccu_pkg::OP_BCCTR: target = {ctr_q[31:2], 2'b00};
			// Old return address is used here; the new one lands at the same edge
			bccu_pkg::OP_BCLR:  target = {ret_q[31:2], 2'b00};
			default: target = absolute_target_flag ? disp_ext : (cia_q + disp_ext);
		endcase
	end

	// Compare
	logic [31:0]          right_opnd;
	bccu_pkg::bccu_cmp_t  cmp_res;
	logic [31:0]          cond_next;
	logic [4:0]           fbase;

	assign right_opnd = (op == bccu_pkg::OP_CMPI) ?
		{{(32 - bccu_pkg::IMM_W){disp_q[bccu_pkg::IMM_W-1]}}, disp_q[bccu_pkg::IMM_W-1:0]} : right_q;

	always_comb begin
		if (op == bccu_pkg::OP_CMPL) begin
			if (left_q < right_opnd) cmp_res = 3'b100;
			else if (left_q > right_opnd) cmp_res = 3'b010;
			else cmp_res = 3'b001;
		end else begin
			if ($signed(left_q) < $signed(right_opnd)) cmp_res = 3'b100;
			else if ($signed(left_q) > $signed(right_opnd)) cmp_res = 3'b010;
			else cmp_res = 3'b001;
		end
	end

	always_comb begin
		fbase = 5'd28 - {target_cond_field, 2'b00};
		cond_next = cond_q;
		cond_next[fbase +: 4] = {cmp_res, sovf_q};
	end

	// Write address and data channels, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			aw_hold_q     <= 1'b0;
			aw_addr_q     <= 8'h00;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_hold_q     <= 1'b1;
				aw_addr_q     <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_hold_q <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_awready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b1;
			w_hold_q     <= 1'b0;
			w_data_q     <= bccu_pkg::RST_WORD;
			w_strb_q     <= 4'h0;
		end else if (ce) begin
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				w_hold_q     <= 1'b1;
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
			end else if (wr_go) begin
				w_hold_q <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= bccu_pkg::RESP_OKAY;
		end else if (ce) begin
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? bccu_pkg::RESP_OKAY : bccu_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Software registers; an execute edge never meets a bus write, as the
	// next write cannot be taken before its response has been accepted
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_q   <= bccu_pkg::RST_WORD;
			cia_q   <= bccu_pkg::RST_WORD;
			disp_q  <= bccu_pkg::RST_WORD;
			left_q  <= bccu_pkg::RST_WORD;
			right_q <= bccu_pkg::RST_WORD;
			sovf_q  <= 1'b0;
			exec_q  <= 1'b0;
		end else if (ce) begin
			exec_q <= wr_go && (aw_addr_q == bccu_pkg::OFF_CMD);
			if (wr_go) begin
				case (aw_addr_q)
					bccu_pkg::OFF_CMD:   cmd_q   <= apply_strb(cmd_q, w_data_q, w_strb_q);
					bccu_pkg::OFF_CIA:   cia_q   <= apply_strb(cia_q, w_data_q, w_strb_q);
					bccu_pkg::OFF_DISP:  disp_q  <= apply_strb(disp_q, w_data_q, w_strb_q);
					bccu_pkg::OFF_LEFT:  left_q  <= apply_strb(left_q, w_data_q, w_strb_q);
					bccu_pkg::OFF_RIGHT: right_q <= apply_strb(right_q, w_data_q, w_strb_q);
					bccu_pkg::OFF_SOVF:  if (w_strb_q[0]) sovf_q <= w_data_q[0];
					default: ;
				endcase
			end
		end
	end

	// Architectural registers that execution also updates
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctr_q  <= bccu_pkg::RST_WORD;
			ret_q  <= bccu_pkg::RST_WORD;
			cond_q <= bccu_pkg::RST_WORD;
		end else if (ce) begin
			if (exec_q) begin
				if (is_branch && !br_invalid && dec_en) ctr_q <= ctr_dec;
				if (is_branch && !br_invalid && link_flag) ret_q <= seq_addr;
				if (is_cmp && !wide_mode) cond_q <= cond_next;
			end else if (wr_go) begin
				if (aw_addr_q == bccu_pkg::OFF_CTR)  ctr_q  <= apply_strb(ctr_q, w_data_q, w_strb_q);
				if (aw_addr_q == bccu_pkg::OFF_RET)  ret_q  <= apply_strb(ret_q, w_data_q, w_strb_q);
				if (aw_addr_q == bccu_pkg::OFF_COND) cond_q <= apply_strb(cond_q, w_data_q, w_strb_q);
			end
		end
	end

	// Results toward fetch
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			next_instr_addr_q <= bccu_pkg::RST_WORD;
			branch_taken_q    <= 1'b0;
			predict_hint_q    <= 1'b0;
			invalid_form_q    <= 1'b0;
			result_valid_q    <= 1'b0;
		end else if (ce) begin
			result_valid_q <= exec_q;
			if (exec_q) begin
				invalid_form_q <= (is_branch && br_invalid) || (is_cmp && wide_mode) || !(is_branch || is_cmp);
				branch_taken_q <= is_branch && !br_invalid && take;
				// Hint goes to fetch and the status word only and feeds nothing above
				predict_hint_q <= is_branch && branch_options[4];
				if (is_branch && !br_invalid) next_instr_addr_q <= take ? target : seq_addr;
				else next_instr_addr_q <= seq_addr;
			end
		end
	end

	// Read channel answers one cycle after the address is taken
	always_comb begin
		rd_hit  = 1'b1;
		rd_word = bccu_pkg::RST_WORD;
		case (s_axi_araddr)
			bccu_pkg::OFF_CMD:   rd_word = cmd_q;
			bccu_pkg::OFF_CIA:   rd_word = cia_q;
			bccu_pkg::OFF_DISP:  rd_word = disp_q;
			bccu_pkg::OFF_CTR:   rd_word = ctr_q;
			bccu_pkg::OFF_RET:   rd_word = ret_q;
			bccu_pkg::OFF_COND:  rd_word = cond_q;
			bccu_pkg::OFF_LEFT:  rd_word = left_q;
			bccu_pkg::OFF_RIGHT: rd_word = right_q;
			bccu_pkg::OFF_SOVF:  rd_word[0] = sovf_q;
			bccu_pkg::OFF_NIA:   rd_word = next_instr_addr_q;
			bccu_pkg::OFF_STAT: begin
				rd_word[bccu_pkg::STAT_TAKEN_BIT]   = branch_taken_q;
				rd_word[bccu_pkg::STAT_HINT_BIT]    = predict_hint_q;
				rd_word[bccu_pkg::STAT_INVALID_BIT] = invalid_form_q;
			end
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= bccu_pkg::RST_WORD;
			s_axi_rresp   <= bccu_pkg::RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_word;
				s_axi_rresp   <= rd_hit ? bccu_pkg::RESP_OKAY : bccu_pkg::RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic go;
	assign go = exec_q && ce;
	a_ctr_decrement: assert property (go && op == bccu_pkg::OP_BC && !branch_options[2]
		|=> ctr_q == $past(ctr_q) - 32'h0000_0001) else $error("counter not decremented");
	a_ctr_untouched: assert property (go && (op == bccu_pkg::OP_BCCTR || branch_options[2])
		|=> ctr_q == $past(ctr_q)) else $error("counter changed unexpectedly");
	a_zero_test: assert property (go && op == bccu_pkg::OP_BC && branch_options[0:3] == 4'b1001
		&& ctr_q == 32'h0000_0001 |=> branch_taken_q) else $error("zero counter test missed");
	a_cond_false: assert property (go && op == bccu_pkg::OP_BC && branch_options[0:2] == 3'b001
		&& cond_bit |=> !branch_taken_q) else $error("branch on false taken on true");
	a_always_taken: assert property (go && op == bccu_pkg::OP_BCLR && branch_options[0]
		&& branch_options[2] |=> branch_taken_q && next_instr_addr_q == {$past(ret_q[31:2]), 2'b00})
		else $error("branch always to return failed");
	// Target rebuilt from the raw register so a broken extension cannot hide
	a_rel_target: assert property (go && op == bccu_pkg::OP_BC && take && !absolute_target_flag
		|=> next_instr_addr_q == $past(cia_q)
		+ 32'($signed($past(disp_q[bccu_pkg::DISP_W-1:0]))) * bccu_pkg::INSTR_STEP)
		else $error("relative target wrong");
	a_link_save: assert property (go && is_branch && link_flag && !br_invalid
		|=> ret_q == $past(cia_q) + bccu_pkg::INSTR_STEP) else $error("return address not saved");
	a_ctr_invalid: assert property (go && br_invalid
		|=> invalid_form_q && !branch_taken_q && ret_q == $past(ret_q)) else $error("invalid form executed");
	a_wide_invalid: assert property (go && is_cmp && wide_mode
		|=> invalid_form_q && cond_q == $past(cond_q)) else $error("wide compare executed");
	a_cmp_onehot: assert property (go && is_cmp && !wide_mode
		|=> $onehot(field_bits(cond_q, $past(target_cond_field)))) else $error("compare result not one-hot");
	a_cmp_signed: assert property (go && op == bccu_pkg::OP_CMP && !wide_mode
		&& $signed(left_q) < $signed(right_q)
		|=> field_bits(cond_q, $past(target_cond_field)) == 3'b100) else $error("signed less not set");
	a_read_answer: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");

	c_bc_taken:   cover property (go && op == bccu_pkg::OP_BC && take);
	c_ctr_branch: cover property (go && op == bccu_pkg::OP_BCCTR && take && branch_options[2]);
	c_cmp_logic:  cover property (go && op == bccu_pkg::OP_CMPL && !wide_mode);
	c_invalid:    cover property (go && br_invalid);

endmodule : bccu_core

/* File: test/bccu_fetch_model.sv */
`timescale 1ns/1ps
module bccu_fetch_model (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Results from the branch unit
	input  wire logic [31:0] next_instr_addr_q,
	input  wire logic        branch_taken_q,
	input  wire logic        predict_hint_q,
	input  wire logic        invalid_form_q,
	input  wire logic        result_valid_q,
	// Redirect as seen by fetch
	output logic             seen_q,
	output logic [31:0]      fetch_addr_q,
	output logic [2:0]       fetch_flags_q
);
	// Fetch only trusts the outputs in the pulse cycle, so latch them there
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seen_q        <= 1'b0;
			fetch_addr_q  <= 32'h0000_0000;
			fetch_flags_q <= 3'h0;
		end else begin
			seen_q <= result_valid_q;
			if (result_valid_q) begin
				fetch_addr_q  <= next_instr_addr_q;
				fetch_flags_q <= {invalid_form_q, predict_hint_q, branch_taken_q};
			end
		end
	end
endmodule : bccu_fetch_model

/* File: test/tb.sv */
`timescale 1ns/1ps
module tb;
	typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} bccu_rd_t;
	typedef struct packed {logic [31:0] next_instr_addr; logic [2:0] fl; logic [2:0] fm;} bccu_res_t;
	logic        aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, tk, hn, inv, rv, seen;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, next_instr_addr, f_addr, r;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [2:0]  f_fl;
	logic [31:0] m_cia, m_disp, m_ctr, m_ret, m_cond, m_left, m_right;
	logic        m_sovf;
	int          errors, cmp_count, seed, i;
	bccu_rd_t    rd_q[$];
	logic [1:0]  b_q[$];
	bccu_rd_t    rx;
	bccu_res_t   res_q[$];
	bccu_res_t   last, mx;

	bccu_core dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.next_instr_addr_q(next_instr_addr), .branch_taken_q(tk), .predict_hint_q(hn),
		.invalid_form_q(inv), .result_valid_q(rv));
	bccu_fetch_model fetch_u (.aclk(aclk), .aresetn(aresetn), .next_instr_addr_q(next_instr_addr),
		.branch_taken_q(tk), .predict_hint_q(hn), .invalid_form_q(inv), .result_valid_q(rv),
		.seen_q(seen), .fetch_addr_q(f_addr), .fetch_flags_q(f_fl));

	task automatic fail(input string s);
		errors++;
		$display("CHECK FAILED t=%0t %s", $time, s);
	endtask : fail

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
		cmp_count++;
		if (g !== e) fail(s);
	endtask : chk

	task automatic complete_run;
		if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : complete_run

	// Waits as long as the slave needs; only the watchdog ends a hung transfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = bccu_pkg::RESP_OKAY);
		b_q.push_back(er);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF,
		input logic [1:0] er = bccu_pkg::RESP_OKAY);
		rd_q.push_back('{e, m, er});
		araddr  <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
	endtask : rd

	// Reference for one command; updates the register model and notes the fetch result
	task automatic exec(input logic [31:0] c);
		logic [4:0]  o;
		logic [31:0] tgt, ofs, cn, a, b;
		logic        t, bad, lt, eq, br;
		int          bi, fi;
		o   = c[8:4];
		bi  = int'(c[13:9]);
		fi  = int'(c[18:16]);
		t   = 1'b0;
		bad = 1'b0;
		br  = c[2:0] < bccu_pkg::OP_CMP;
		tgt = m_cia + bccu_pkg::INSTR_STEP;
		ofs = {{16{m_disp[13]}}, m_disp[13:0], 2'b00};
		if (c[2:0] == bccu_pkg::OP_BCCTR) begin
			bad = !o[2];
			if (!bad) begin
				t = o[4] | (m_cond[31-bi] == o[3]);
				if (t) tgt = {m_ctr[31:2], 2'b00};
				if (c[15]) m_ret = m_cia + bccu_pkg::INSTR_STEP;
			end
		end else if (br) begin
			cn = o[2] ? m_ctr : m_ctr - 32'h0000_0001;
			t = (o[2] | ((cn != 0) ^ o[1])) & (o[4] | (m_cond[31-bi] == o[3]));
			if (t && c[2:0] == bccu_pkg::OP_BCLR) tgt = {m_ret[31:2], 2'b00};
			else if (t) tgt = c[14] ? ofs : m_cia + ofs;
			m_ctr = cn;
			if (c[15]) m_ret = m_cia + bccu_pkg::INSTR_STEP;
		end else if (c[19] || c[2:0] > bccu_pkg::OP_CMPL) begin
			bad = 1'b1;
		end else begin
			a  = m_left;
			b  = (c[2:0] == bccu_pkg::OP_CMPI) ? {{16{m_disp[15]}}, m_disp[15:0]} : m_right;
			lt = (c[2:0] == bccu_pkg::OP_CMPL) ? a < b : $signed(a) < $signed(b);
			eq = a == b;
			m_cond[31-4*fi -: 4] = {lt, !lt && !eq, eq, m_sovf};
		end
		last = '{tgt, {bad, br & o[0], t}, {1'b1, !(br && bad), 1'b1}};
		res_q.push_back(last);
		wr(bccu_pkg::OFF_CMD, c);
	endtask : exec

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		if (seen === 1'b1) begin
			if (res_q.size() == 0) fail("unexpected result");
			else begin
				mx = res_q.pop_front();
				chk(f_addr, mx.next_instr_addr, "next address");
				chk({29'h0, f_fl & mx.fm}, {29'h0, mx.fl & mx.fm}, "status flags");
			end
		end
		if (bvalid === 1'b1 && bready) begin
			if (b_q.size() == 0) fail("unexpected write response");
			else chk({30'h0, bresp}, {30'h0, b_q.pop_front()}, "write response");
		end
		if (rvalid === 1'b1 && rready) begin
			if (rd_q.size() == 0) fail("unexpected read data");
			else begin
				rx = rd_q.pop_front();
				chk(rdata & rx.m, rx.d & rx.m, "read data");
				chk({30'h0, rresp}, {30'h0, rx.r}, "read response");
			end
		end
	end

	initial begin
		#(20 * 60000);
		fail("watchdog");
		complete_run();
	end

	initial begin
		seed = 17;
		{errors, cmp_count} = '0;
		{aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
		{ce, bready, rready, wstrb} = 7'h7F;
		{m_cia, m_disp, m_ctr, m_ret, m_cond, m_left, m_right, m_sovf} = '0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(bccu_pkg::OFF_STAT, 32'h0000_0000);
		rd(bccu_pkg::OFF_NIA, 32'h0000_0000);
		wr(8'h2C, 32'h1234_5678, bccu_pkg::RESP_SLVERR);
		wr(bccu_pkg::OFF_NIA, 32'h1234_5678, bccu_pkg::RESP_SLVERR);
		rd(8'h30, 32'h0000_0000, 32'hFFFF_FFFF, bccu_pkg::RESP_SLVERR);
		rd(bccu_pkg::OFF_NIA, 32'h0000_0000);
		for (i = 0; i < 150; i++) begin
			m_cia   = $random(seed) & 32'hFFFF_FFFC;
			m_disp  = $random(seed);
			m_ctr   = (i % 3 == 0) ? {$random(seed)} % 3 : $random(seed);
			m_ret   = $random(seed);
			m_cond  = $random(seed);
			m_left  = $random(seed);
			m_right = (i % 4 == 0) ? m_left : $random(seed);
			r       = $random(seed);
			m_sovf  = r[0];
			wr(bccu_pkg::OFF_CIA, m_cia);
			wr(bccu_pkg::OFF_DISP, m_disp);
			wr(bccu_pkg::OFF_CTR, m_ctr);
			wr(bccu_pkg::OFF_RET, m_ret);
			wr(bccu_pkg::OFF_COND, m_cond);
			wr(bccu_pkg::OFF_LEFT, m_left);
			wr(bccu_pkg::OFF_RIGHT, m_right);
			wr(bccu_pkg::OFF_SOVF, r);
			r       = $random(seed);
			r[19]   = (i % 8 == 0);
			// Half the commands keep the ignored option bits clear, half leave them random
			if (i % 2 == 0) begin
				if (r[8]) r[7] = 1'b0;
				if (r[6]) r[5] = 1'b0;
				if (r[8] && r[6]) r[4] = 1'b0;
			end
			exec(r);
			rd(bccu_pkg::OFF_CTR, m_ctr);
			rd(bccu_pkg::OFF_RET, m_ret);
			rd(bccu_pkg::OFF_COND, m_cond);
			rd(bccu_pkg::OFF_NIA, last.next_instr_addr);
			rd(bccu_pkg::OFF_STAT, {29'h0, last.fl}, {29'h0, last.fm});
			rd(bccu_pkg::OFF_SOVF, {31'h0, m_sovf}, 32'h0000_0001);
		end
		repeat (10) @(posedge aclk);
		if (res_q.size() != 0 || rd_q.size() != 0 || b_q.size() != 0) fail("results missing");
		complete_run();
	end
endmodule : tb
